// >>> core/wdrl_pkg.sv
package wdrl_pkg;
  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int CNT_W = 24;

  // ----------------------------------------------------------------
  // register indices and byte addresses (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [11:0] IDX_UNLOCK_CTL = 12'hFF0;
  localparam logic [11:0] IDX_RELOAD_UPPER = 12'hFF1;
  localparam logic [11:0] IDX_RELOAD_MIDDLE = 12'hFF2;
  localparam logic [11:0] IDX_RELOAD_LOW = 12'hFF3;
  localparam logic [ADDR_W-1:0] ADDR_UNLOCK_CTL = {2'h0, IDX_UNLOCK_CTL, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_RELOAD_UPPER = {2'h0, IDX_RELOAD_UPPER, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_RELOAD_MIDDLE = {2'h0, IDX_RELOAD_MIDDLE, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_RELOAD_LOW = {2'h0, IDX_RELOAD_LOW, 2'h0};

  // ----------------------------------------------------------------
  // field positions inside the 24-bit reload value
  // ----------------------------------------------------------------
  localparam int UPPER_LSB = 16;
  localparam int MIDDLE_LSB = 8;
  localparam int LOW_LSB = 0;

  // ----------------------------------------------------------------
  // reset values and keys
  // ----------------------------------------------------------------
  localparam logic [7:0] RELOAD_UPPER_RST = 8'h00;
  localparam logic [7:0] RELOAD_MIDDLE_RST = 8'h04;
  localparam logic [7:0] RELOAD_LOW_RST = 8'h00;
  localparam logic [CNT_W-1:0] RELOAD_RST = {RELOAD_UPPER_RST, RELOAD_MIDDLE_RST, RELOAD_LOW_RST};
  localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_KEY_SECOND = 8'hAA;

  // ----------------------------------------------------------------
  // axi responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // unlock detector states
  typedef enum logic [1:0] {
    WDRL_LOCKED = 2'b00,
    WDRL_SEEN_FIRST = 2'b01,
    WDRL_UNLOCKED = 2'b10
  } wdrl_lock_e;
endpackage

// >>> core/wdrl_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - reload bytes become writable only after 55H then AAH are written to the unlock control address.
// - the unlock bytes change only the internal lock state, no stored control bits.
// - the control address is write-only; reading it returns the separate reset status byte.
// - while locked, writes to the reload bytes are dropped.
// - each refresh instruction loads the 24-bit reload value into the counter.
// - a reload write updates its stored byte; a reload read returns that byte of the live count.
// - upper byte is bits 23:16, middle byte bits 15:8, low byte bits 7:0.
module wdrl_top
  import wdrl_pkg::*;
(
  input wire logic core_clk, // system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic ce, // clock enable, freezes all state
  input wire logic [wdrl_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [wdrl_pkg::DATA_W-1:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [wdrl_pkg::ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [wdrl_pkg::DATA_W-1:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic watchdog_refresh_instruction, // refresh executed, one-cycle pulse
  input wire logic [7:0] reset_status, // reset status byte from reset logic
  output logic [wdrl_pkg::CNT_W-1:0] count_o, // live watchdog count
  output logic count_zero_o // count has reached zero
);
  import wdrl_pkg::*;

  wdrl_unlock_if ulk ();

  // ----------------------------------------------------------------
  // write channel state
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] aw_addr_r;
  logic aw_full_r;
  logic [7:0] w_byte_r;
  logic w_en_r;
  logic w_full_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic aw_take;
  logic w_take;
  logic b_done;
  logic wr_fire;
  logic aw_full_nxt;
  logic w_full_nxt;
  logic bvalid_nxt;

  // ----------------------------------------------------------------
  // read channel state
  // ----------------------------------------------------------------
  logic arready_r;
  logic rvalid_r;
  logic [DATA_W-1:0] rdata_r;
  logic [1:0] rresp_r;
  logic ar_take;
  logic rvalid_nxt;

  // ----------------------------------------------------------------
  // reload and counter
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] reload_r;
  logic [CNT_W-1:0] count_r;
  logic count_zero_r;
  logic [CNT_W-1:0] count_nxt;

  // write decode
  logic wr_ctl;
  logic wr_upper;
  logic wr_middle;
  logic wr_low;
  logic wr_mapped;
  logic reload_wr_ok;

  // read decode
  logic rd_ctl;
  logic rd_upper;
  logic rd_middle;
  logic rd_low;
  logic rd_mapped;
  logic [7:0] rd_byte;

  // handshakes
  assign aw_take = s_axi_awvalid && awready_r;
  assign w_take = s_axi_wvalid && wready_r;
  assign b_done = bvalid_r && s_axi_bready;
  assign ar_take = s_axi_arvalid && arready_r;

  // the write fires once address and data are both held
  assign wr_fire = aw_full_r && w_full_r && !bvalid_r;
  assign aw_full_nxt = wr_fire ? 1'b0 : (aw_full_r || aw_take);
  assign w_full_nxt = wr_fire ? 1'b0 : (w_full_r || w_take);
  assign bvalid_nxt = wr_fire ? 1'b1 : (bvalid_r && !b_done);
  assign rvalid_nxt = ar_take ? 1'b1 : (rvalid_r && !(rvalid_r && s_axi_rready));

  // write address decode, lane 0 carries the byte
  assign wr_ctl = (aw_addr_r == ADDR_UNLOCK_CTL);
  assign wr_upper = (aw_addr_r == ADDR_RELOAD_UPPER);
  assign wr_middle = (aw_addr_r == ADDR_RELOAD_MIDDLE);
  assign wr_low = (aw_addr_r == ADDR_RELOAD_LOW);
  assign wr_mapped = wr_ctl || wr_upper || wr_middle || wr_low;
  assign reload_wr_ok = wr_fire && w_en_r && ulk.unlocked;

  // unlock detector sees control writes only; nothing is stored for them
  assign ulk.ctl_wr = wr_fire && w_en_r && wr_ctl;
  assign ulk.unlock_key_field = w_byte_r;

  // read address decode
  assign rd_ctl = (s_axi_araddr == ADDR_UNLOCK_CTL);
  assign rd_upper = (s_axi_araddr == ADDR_RELOAD_UPPER);
  assign rd_middle = (s_axi_araddr == ADDR_RELOAD_MIDDLE);
  assign rd_low = (s_axi_araddr == ADDR_RELOAD_LOW);
  assign rd_mapped = rd_ctl || rd_upper || rd_middle || rd_low;

  // read mux: status at the control address, live count bytes at the reload addresses, zero elsewhere
  assign rd_byte = rd_ctl ? reset_status
                 : rd_upper ? count_r[UPPER_LSB +: 8]
                 : rd_middle ? count_r[MIDDLE_LSB +: 8]
                 : rd_low ? count_r[LOW_LSB +: 8]
                 : 8'h00;

  // counter: refresh reloads, otherwise count down to zero and hold
  assign count_nxt = watchdog_refresh_instruction ? reload_r
                   : (count_r == '0) ? count_r
                   : count_r - CNT_W'(1);

  // ----------------------------------------------------------------
  // unlock detector
  // ----------------------------------------------------------------
  wdrl_unlock u_unlock (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .lk(ulk.lock)
  );

  // write address and data holding
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      aw_addr_r <= '0;
      w_byte_r <= 8'h00;
      w_en_r <= 1'b0;
    end
    else if (ce)
    begin
      if (aw_take)
        aw_addr_r <= s_axi_awaddr;
      if (w_take)
      begin
        w_byte_r <= s_axi_wdata[7:0];
        w_en_r <= s_axi_wstrb[0];
      end
    end
  end

  // write channel handshake and response
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end
    else if (ce)
    begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      awready_r <= !aw_full_nxt && !bvalid_nxt;
      wready_r <= !w_full_nxt && !bvalid_nxt;
      bvalid_r <= bvalid_nxt;
      if (wr_fire)
        bresp_r <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // read channel: data captured at the address handshake
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end
    else if (ce)
    begin
      arready_r <= !rvalid_nxt;
      rvalid_r <= rvalid_nxt;
      if (ar_take)
      begin
        rdata_r <= {24'h000000, rd_byte};
        rresp_r <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // reload bytes and live counter
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
      reload_r <= RELOAD_RST;
    else if (ce && reload_wr_ok)
    begin
      if (wr_upper)
        reload_r[UPPER_LSB +: 8] <= w_byte_r;
      if (wr_middle)
        reload_r[MIDDLE_LSB +: 8] <= w_byte_r;
      if (wr_low)
        reload_r[LOW_LSB +: 8] <= w_byte_r;
    end
  end

  // count register and zero flag
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      count_r <= RELOAD_RST;
      count_zero_r <= 1'b0;
    end
    else if (ce)
    begin
      count_r <= count_nxt;
      count_zero_r <= (count_nxt == '0);
    end
  end

  // outputs
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign count_o = count_r;
  assign count_zero_o = count_zero_r;
endmodule // wdrl_top

// >>> core/wdrl_unlock.sv
`timescale 1ns/1ps
module wdrl_unlock
  import wdrl_pkg::*;
(
  input wire logic core_clk, // system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic ce, // clock enable
  wdrl_unlock_if.lock lk // control writes in, lock state out
);
  import wdrl_pkg::*;

  wdrl_lock_e state_r;
  wdrl_lock_e state_nxt;
  logic is_first;
  logic is_second;

  // ----------------------------------------------------------------
  // key decode
  // ----------------------------------------------------------------
  assign is_first = (lk.unlock_key_field == UNLOCK_KEY_FIRST);
  assign is_second = (lk.unlock_key_field == UNLOCK_KEY_SECOND);
  assign lk.unlocked = (state_r == WDRL_UNLOCKED);

  // next state: only control writes move it
  always_comb
  begin
    state_nxt = state_r;
    if (lk.ctl_wr)
    begin
      case (state_r)
        WDRL_LOCKED: state_nxt = is_first ? WDRL_SEEN_FIRST : WDRL_LOCKED;
        WDRL_SEEN_FIRST: state_nxt = is_second ? WDRL_UNLOCKED
                                   : (is_first ? WDRL_SEEN_FIRST : WDRL_LOCKED);
        WDRL_UNLOCKED: state_nxt = is_first ? WDRL_SEEN_FIRST : WDRL_LOCKED;
        default: state_nxt = WDRL_LOCKED;
      endcase
    end
  end

  // state register
  always_ff @(posedge core_clk)
  begin
    if (rst)
      state_r <= WDRL_LOCKED;
    else if (ce)
      state_r <= state_nxt;
  end
endmodule // wdrl_unlock

// >>> core/wdrl_unlock_if.sv
`timescale 1ns/1ps
interface wdrl_unlock_if;
  logic ctl_wr; // write to the unlock control address
  logic [7:0] unlock_key_field; // byte written with it
  logic unlocked; // reload bytes may be changed
  modport ctrl (output ctl_wr, output unlock_key_field, input unlocked);
  modport lock (input ctl_wr, input unlock_key_field, output unlocked);
endinterface

// >>> verification/watchdog_reload_unlock_regs_tb_top.sv
`timescale 1ns/1ps
module watchdog_reload_unlock_regs_tb_top;
  import wdrl_pkg::*;
  localparam logic [7:0] STATUS = 8'h5A;
  logic core_clk = 1'b0, rst = 1'b1, ce = 1'b1, refresh_req = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, count_zero_o;
  logic watchdog_refresh_instruction;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] reset_status;
  logic [CNT_W-1:0] count_o;
  int fail_count = 0, checked = 0;

  wdrl_top u_wdrl_top (.core_clk, .rst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .watchdog_refresh_instruction, .reset_status, .count_o, .count_zero_o);
  wdrl_core_model #(.STATUS(STATUS)) u_wdrl_core_model (.core_clk, .refresh_req,
    .watchdog_refresh_instruction, .reset_status);

  // 40 mhz clock
  initial forever #12.5 core_clk = ~core_clk;

  // -----------------------------------------------------------
  // helpers
  // -----------------------------------------------------------
  task automatic complete_run();
    if (fail_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // response accepted one cycle after it shows, so its hold is exercised
    do
    begin
      @(posedge core_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
    end
    while (!(s_axi_bvalid && s_axi_bready) && n < 50);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (!(s_axi_bvalid && s_axi_bready))
    begin
      fail_count++;
      complete_run();
    end
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    // read data accepted one cycle after it shows, so its hold is exercised
    do
    begin
      @(posedge core_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
    end
    while (!(s_axi_rvalid && s_axi_rready) && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (!(s_axi_rvalid && s_axi_rready))
    begin
      fail_count++;
      complete_run();
    end
  endtask

  // request one refresh, return just after the edge that reloads
  task automatic refresh();
    @(posedge core_clk) refresh_req <= 1'b1;
    @(posedge core_clk) refresh_req <= 1'b0;
    @(posedge core_clk) #1;
  endtask

  task automatic wr3(input logic [7:0] k0, input logic [7:0] k1, input logic [7:0] k2, input logic [ADDR_W-1:0] a2);
    logic [1:0] r;
    wr(ADDR_UNLOCK_CTL, k0, r);
    wr(ADDR_UNLOCK_CTL, k1, r);
    wr(a2, k2, r);
  endtask

  task automatic load(input logic [CNT_W-1:0] v);
    logic [1:0] r;
    wr(ADDR_RELOAD_UPPER, v[23:16], r);
    wr(ADDR_RELOAD_MIDDLE, v[15:8], r);
    wr(ADDR_RELOAD_LOW, v[7:0], r);
    chk(r, RESP_OKAY);
  endtask

  // -----------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------
  task automatic s_locked();
    logic [1:0] r;
    load(24'h123456);
    refresh();
    chk(count_o, RELOAD_RST);
    wr3(8'h55, 8'h11, 8'hAA, ADDR_UNLOCK_CTL);
    load(24'h123456);
    refresh();
    chk(count_o, RELOAD_RST);
    // key bytes with lane 0 masked must not count towards the unlock
    @(posedge core_clk) s_axi_wstrb <= 4'h0;
    wr(ADDR_UNLOCK_CTL, UNLOCK_KEY_FIRST, r);
    wr(ADDR_UNLOCK_CTL, UNLOCK_KEY_SECOND, r);
    @(posedge core_clk) s_axi_wstrb <= 4'hF;
    wr(ADDR_RELOAD_UPPER, 8'h99, r);
    chk(r, RESP_OKAY);
    refresh();
    chk(count_o, RELOAD_RST);
  endtask

  task automatic s_unlock_live();
    logic [31:0] d;
    logic [1:0] r;
    wr3(UNLOCK_KEY_FIRST, UNLOCK_KEY_SECOND, 8'h12, ADDR_RELOAD_UPPER);
    wr(ADDR_RELOAD_MIDDLE, 8'h34, r);
    wr(ADDR_RELOAD_LOW, 8'h56, r);
    refresh();
    chk(count_o, 24'h123456);
    rd(ADDR_RELOAD_UPPER, d, r);
    chk(d, 32'h12);
    rd(ADDR_RELOAD_MIDDLE, d, r);
    chk(d, 32'h34);
    rd(ADDR_RELOAD_LOW, d, r);
    chk(d[7:0] < 8'h56, 1'b1);
  endtask

  task automatic s_status();
    logic [31:0] d;
    logic [1:0] r;
    wr(ADDR_UNLOCK_CTL, UNLOCK_KEY_FIRST, r);
    rd(ADDR_UNLOCK_CTL, d, r);
    chk(d, {24'h0, STATUS});
    chk(r, RESP_OKAY);
    wr(16'h0000, 8'h12, r);
    chk(r, RESP_SLVERR);
    rd(16'h0000, d, r);
    chk(r, RESP_SLVERR);
  endtask

  task automatic s_freeze();
    logic [CNT_W-1:0] c;
    @(posedge core_clk) ce <= 1'b0;
    @(posedge core_clk) #1 c = count_o;
    repeat (3) @(posedge core_clk);
    #1 chk(count_o, c);
    @(posedge core_clk) ce <= 1'b1;
  endtask

  task automatic s_zero();
    wr3(UNLOCK_KEY_FIRST, UNLOCK_KEY_SECOND, 8'h00, ADDR_RELOAD_UPPER);
    load(24'h000004);
    refresh();
    chk(count_o, 24'h000004);
    repeat (6) @(posedge core_clk);
    #1 chk(count_o, 24'h0);
    chk(count_zero_o, 1'b1);
  endtask

  // main sequence
  initial
  begin
    repeat (20) @(posedge core_clk);
    #1 chk(count_o, RELOAD_RST);
    @(posedge core_clk) rst <= 1'b0;
    s_locked();
    s_unlock_live();
    s_status();
    s_freeze();
    s_zero();
    complete_run();
  end
endmodule // watchdog_reload_unlock_regs_tb_top

// >>> verification/wdrl_core_model.sv
`timescale 1ns/1ps
module wdrl_core_model #(
  parameter logic [7:0] STATUS = 8'h5A // arbitrary reset cause byte
)
(
  input wire logic core_clk, // clock
  input wire logic refresh_req, // bench asks for one refresh
  output logic watchdog_refresh_instruction, // one-cycle refresh pulse
  output logic [7:0] reset_status // reset cause byte
);
  // refresh pulse launched one edge after the request
  always_ff @(posedge core_clk)
    watchdog_refresh_instruction <= refresh_req;
  assign reset_status = STATUS;
endmodule // wdrl_core_model

// >>> verification/wdrl_top_monitor.sv
`timescale 1ns/1ps
module wdrl_top_monitor
  import wdrl_pkg::*;
(
  input wire logic core_clk, // clock
  input wire logic rst, // reset
  input wire logic ce, // enable
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [wdrl_pkg::DATA_W-1:0] s_axi_rdata, // read data
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic watchdog_refresh_instruction, // refresh pulse
  input wire logic [wdrl_pkg::CNT_W-1:0] count_o, // live count
  input wire logic count_zero_o // zero flag
);
  // one clock domain for every check
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_rst;
    @(posedge core_clk) disable iff (1'b0) rst |=> count_o == 24'h000400 && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_rst: assert property (p_rst) else $error("state after reset wrong");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  property p_r_zero;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
  endproperty
  a_r_zero: assert property (p_r_zero) else $error("upper read bits set");
  property p_r_lat;
    ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_b_lat;
    ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("write answer late");
  property p_dec;
    ce && !watchdog_refresh_instruction && count_o != 24'h0 |=> count_o == $past(count_o) - 24'h1;
  endproperty
  a_dec: assert property (p_dec) else $error("count did not step down");
  property p_freeze;
    !ce |=> $stable(count_o);
  endproperty
  a_freeze: assert property (p_freeze) else $error("count moved while disabled");
  property p_zero;
    count_zero_o == (count_o == 24'h0);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
endmodule // wdrl_top_monitor

bind wdrl_top wdrl_top_monitor u_wdrl_top_monitor (.core_clk, .rst, .ce, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .watchdog_refresh_instruction, .count_o, .count_zero_o);
